// ===== src/i2c_engine_cfg.svh
`ifndef I2C_ENGINE_CFG_SVH
`define I2C_ENGINE_CFG_SVH
// ==========================================
// Register offsets (byte wide, own choice of indices)
`define I2C_OFF_CTRL 3'h0
`define I2C_OFF_ST1 3'h1
`define I2C_OFF_ST2 3'h2
`define I2C_OFF_CLK 3'h3
`define I2C_OFF_DATA 3'h4
// ==========================================
// Control field positions
`define I2C_CTL_ITE 0
`define I2C_CTL_STOP 1
`define I2C_CTL_ACK 2
`define I2C_CTL_START 3
`define I2C_CTL_EN 5
// ==========================================
// Reset values
`define I2C_CTRL_RST 8'h00
`define I2C_CLK_RST 8'h00
`define I2C_DATA_RST 8'h00
// ==========================================
// Timing: standard splits a bit in 2 phases, fast in 3
`define I2C_STD_PHASES 2'h2
`define I2C_FAST_PHASES 2'h3
`define I2C_DIV_OFFSET 8'h02
`endif

// ===== src/i2c_engine_pkg.sv
package i2c_engine_pkg;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic o;
      logic oe;
   } od_pin_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_START_A, ST_START_B, ST_WAIT_ADDR, ST_BIT_LO, ST_BIT_HI,
      ST_WAIT, ST_STOP_A, ST_STOP_B, ST_STOP_C
   } eng_state_t;
endpackage

// ===== src/i2c_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Three-stage synchroniser; a change counts when stages two and three agree
module i2c_pin_sync (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         level_o <= 1'b1;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level_o <= s3;
         end
      end
   end
endmodule
`default_nettype wire

// ===== src/i2c_phase_tick.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Phase divider: one tick every (divider+2) cycles
module i2c_phase_tick #(
   parameter int DIV_W = 7
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic tick_o
);
   logic [DIV_W:0] cnt;
   wire [DIV_W:0] limit = {1'b0, div_i} + (DIV_W+1)'(1);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= '0;
         tick_o <= 1'b0;
      end else if (!run_i || cnt >= limit) begin
         cnt <= '0;
         tick_o <= run_i;
      end else begin
         cnt <= cnt + (DIV_W+1)'(1);
         tick_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== src/i2c_single_master_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "i2c_engine_cfg.svh"
// Behaviour
// (R1) Idle after reset; master on start, back to idle after stop.
// (R2) Engine drives clock; start and stop come from control bits.
// (R3) Bytes shifted MSB first; first byte after start is the address.
// (R4) Ninth clock pulse after each byte carries the acknowledge.
// (R5) Control bit enables returning acknowledge on received bytes.
// (R6) Speed select chooses standard or fast range.
// (R7) Transmitting: clock held low until software writes next byte.
// (R8) Receiving: clock held low until software reads received byte.
// (R9) Bus clock from programmable divider, dependent on speed select.
// (R10) Pins open-drain while enabled, released when disabled.
// (R11) Start request: master flag, start condition, event and start flags.
// (R12) After start, hold clock until status read then address write.
// (R13) After address, event flag; hold until status read and control write.
// (R14) Receiver: acknowledge pulse if enabled, then event and byte flags.
// (R15) Receiver waits for status read then data read before next byte.
// (R16) Stop set before final read ends reception and returns to idle.
// (R17) Software clears acknowledge before reading second-to-last byte.
// (R18) Transmitter waits status read plus data write; ack sets flags.
// (R19) Stop set after final write ends transmission after that byte.
// (R20) Missing ack sets event and failure flags, no hold, resume on start/stop.
// (R21) Bus clock = clk/(2*(div+2)) standard, clk/(3*(div+2)) fast.
// (R22) Enable clear resets control and status except stop, releases outputs.
// (R23) First enabling write only sets enable; second write applies rest.
// (R24) Status read recorded; pending event cleared only by matching access.
module i2c_single_master_engine (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire i2c_engine_pkg::reg_req_t req_i,
   output logic [7:0] rdata_o,
   output logic irq_o,
   input wire logic serial_clock_pin_i,
   output i2c_engine_pkg::od_pin_t serial_clock_pin_o,
   input wire logic serial_data_pin_i,
   output i2c_engine_pkg::od_pin_t serial_data_pin_o,
   output logic pins_owned_o
);
   import i2c_engine_pkg::*;
   // ==========================================
   // Registers
   logic block_enable;
   logic start_req;
   logic ack_en;
   logic stop_req;
   logic irq_enable;
   logic [7:0] clk_reg;
   logic [7:0] data_reg;
   logic event_flag;
   logic start_sent_flag;
   logic byte_done_flag;
   logic ack_failure_flag;
   logic tx_flag;
   logic master_idle_state;
   logic addr_flag;
   logic st1_seen;
   eng_state_t state;
   logic [7:0] shreg;
   logic [3:0] bitn;
   logic [1:0] ph;
   logic is_addr;
   logic rx_mode;
   logic scl_low;
   logic sda_low;
   logic scl_s;
   logic sda_s;
   logic tick;
   // ==========================================
   // Decode
   wire rd_ctrl = req_i.rd && req_i.addr == `I2C_OFF_CTRL;
   wire rd_st1 = req_i.rd && req_i.addr == `I2C_OFF_ST1;
   wire rd_st2 = req_i.rd && req_i.addr == `I2C_OFF_ST2;
   wire rd_data = req_i.rd && req_i.addr == `I2C_OFF_DATA;
   wire wr_ctrl = req_i.wr && req_i.addr == `I2C_OFF_CTRL;
   wire wr_clk = req_i.wr && req_i.addr == `I2C_OFF_CLK;
   wire wr_data = req_i.wr && req_i.addr == `I2C_OFF_DATA;
   // Sequence completions need a prior status read (R24)
   wire seq_wr_data = wr_data && st1_seen;
   wire seq_rd_data = rd_data && st1_seen;
   wire seq_wr_ctrl = wr_ctrl && st1_seen;
   wire clr_sb = seq_wr_data && start_sent_flag;
   wire clr_addr = seq_wr_ctrl && addr_flag;
   wire clr_btf = byte_done_flag && (tx_flag ? seq_wr_data : seq_rd_data);
   // Phases per bit: 2 standard, 3 fast (R6) (R9) (R21)
   // Low phase takes all divider phases but the last; high phase takes one
   wire [1:0] last_ph = clk_reg[7] ? `I2C_FAST_PHASES - 2'h2 : `I2C_STD_PHASES - 2'h2;
   wire ph_end = tick && ph == last_ph;
   wire hold = start_sent_flag || byte_done_flag || addr_flag;
   wire [7:0] st1_val = {event_flag, 1'b0, tx_flag, 1'b0, byte_done_flag, 1'b0,
                         master_idle_state, start_sent_flag};
   wire [7:0] ctrl_val = {2'b00, block_enable, 1'b0, start_req, ack_en, stop_req, irq_enable};
   wire [7:0] next_rdata = rd_ctrl ? ctrl_val :
                           rd_st1 ? st1_val :
                           rd_st2 ? {3'b000, ack_failure_flag, 4'h0} :
                           (req_i.rd && req_i.addr == `I2C_OFF_CLK) ? clk_reg :
                           rd_data ? data_reg : 8'h00;
   // Event set by hardware this cycle
   logic set_sb;
   logic set_addr;
   logic set_btf;
   logic set_af;
   logic stop_done;
   i2c_phase_tick #(.DIV_W(7)) u_tick (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(block_enable && state != ST_IDLE && state != ST_WAIT && state != ST_WAIT_ADDR),
      .div_i(clk_reg[6:0]),
      .tick_o(tick)
   );
   i2c_pin_sync u_scl (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(serial_clock_pin_i),
      .level_o(scl_s)
   );
   i2c_pin_sync u_sda (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(serial_data_pin_i),
      .level_o(sda_s)
   );
   // ==========================================
   // Control register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {block_enable, start_req, ack_en, stop_req, irq_enable} <= 5'h00;
         clk_reg <= `I2C_CLK_RST;
      end else begin
         if (wr_clk) begin
            clk_reg <= req_i.wdata;
         end
         if (wr_ctrl && !req_i.wdata[`I2C_CTL_EN]) begin
            block_enable <= 1'b0; // (R22)
            {start_req, ack_en, irq_enable} <= 3'b000;
            stop_req <= req_i.wdata[`I2C_CTL_STOP];
         end else if (wr_ctrl && !block_enable) begin
            block_enable <= 1'b1; // (R23)
         end else if (wr_ctrl) begin
            start_req <= req_i.wdata[`I2C_CTL_START]; // (R2)
            ack_en <= req_i.wdata[`I2C_CTL_ACK]; // (R5)
            stop_req <= req_i.wdata[`I2C_CTL_STOP];
            irq_enable <= req_i.wdata[`I2C_CTL_ITE];
         end else begin
            if (set_sb) begin
               start_req <= 1'b0;
            end
            if (stop_done) begin
               stop_req <= 1'b0;
            end
         end
      end
   end
   // ==========================================
   // Status flags; hardware set wins over software clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {event_flag, start_sent_flag, byte_done_flag, ack_failure_flag} <= 4'h0;
         {tx_flag, addr_flag, st1_seen} <= 3'b000;
      end else if (!block_enable) begin
         {event_flag, start_sent_flag, byte_done_flag, ack_failure_flag} <= 4'h0; // (R22)
         {tx_flag, addr_flag, st1_seen} <= 3'b000;
      end else begin
         if (rd_st1) begin
            st1_seen <= 1'b1; // (R24)
         end else if (req_i.rd || req_i.wr) begin
            st1_seen <= 1'b0;
         end
         start_sent_flag <= set_sb || (start_sent_flag && !clr_sb); // (R11)
         addr_flag <= set_addr || (addr_flag && !clr_addr); // (R13)
         byte_done_flag <= set_btf || (byte_done_flag && !clr_btf); // (R14) (R18)
         ack_failure_flag <= set_af || (ack_failure_flag && !rd_st2); // (R20)
         if (set_btf) begin
            tx_flag <= !rx_mode;
         end else if (clr_btf) begin
            tx_flag <= 1'b0;
         end
         event_flag <= set_sb || set_addr || set_btf || set_af ||
                       (event_flag && !(clr_sb || clr_addr || clr_btf || (rd_st2 && ack_failure_flag)));
      end
   end
   // ==========================================
   // Bus engine; each bit is low phase then high phase of the divided clock
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE; // (R1)
         master_idle_state <= 1'b0;
         {scl_low, sda_low, is_addr, rx_mode} <= 4'h0;
         shreg <= 8'h00;
         bitn <= 4'h0;
         ph <= 2'h0;
         data_reg <= `I2C_DATA_RST;
         {set_sb, set_addr, set_btf, set_af, stop_done} <= 5'h00;
      end else if (!block_enable) begin
         state <= ST_IDLE; // (R10) (R22)
         master_idle_state <= 1'b0;
         {scl_low, sda_low, is_addr, rx_mode} <= 4'h0;
         ph <= 2'h0;
         {set_sb, set_addr, set_btf, set_af, stop_done} <= 5'h00;
      end else begin
         {set_sb, set_addr, set_btf, set_af, stop_done} <= 5'h00;
         if (wr_data) begin
            data_reg <= req_i.wdata;
         end
         if (tick) begin
            ph <= (ph_end || state == ST_BIT_HI) ? 2'h0 : ph + 2'h1; // (R21)
         end
         case (state)
            ST_IDLE: begin
               if (start_req && scl_s && sda_s) begin
                  master_idle_state <= 1'b1; // (R1) (R11)
                  state <= ST_START_A;
               end
            end
            ST_START_A: begin
               // Release lines high before the falling data edge, serves repeated start
               sda_low <= 1'b0;
               if (ph_end && scl_low) begin
                  scl_low <= 1'b0;
               end else if (ph_end) begin
                  state <= ST_START_B;
               end
            end
            ST_START_B: begin
               sda_low <= 1'b1; // (R2)
               if (ph_end) begin
                  scl_low <= 1'b1;
                  set_sb <= 1'b1; // (R11)
                  is_addr <= 1'b1; // (R3)
                  rx_mode <= 1'b0;
                  state <= ST_WAIT_ADDR;
               end
            end
            ST_WAIT_ADDR: begin
               if (clr_sb) begin
                  shreg <= req_i.wdata; // (R12)
                  rx_mode <= req_i.wdata[0];
                  bitn <= 4'h0;
                  state <= ST_BIT_LO;
               end
            end
            ST_BIT_LO: begin
               scl_low <= 1'b1;
               if (bitn == 4'h8) begin
                  // Ninth pulse: master drives ack only when receiving data (R4) (R14)
                  sda_low <= rx_mode && !is_addr && ack_en; // (R5)
               end else begin
                  sda_low <= (rx_mode && !is_addr) ? 1'b0 : !shreg[7]; // (R3)
               end
               if (ph_end) begin
                  state <= ST_BIT_HI;
               end
            end
            ST_BIT_HI: begin
               scl_low <= 1'b0;
               // No stretch detection: pin sync lag would distort the bit period
               if (tick) begin
                  if (bitn == 4'h8) begin
                     bitn <= 4'h0;
                     scl_low <= 1'b1;
                     if ((!rx_mode || is_addr) && sda_s) begin
                        set_af <= 1'b1; // (R20)
                        state <= ST_WAIT;
                     end else if (is_addr) begin
                        set_addr <= 1'b1; // (R13)
                        state <= ST_WAIT;
                     end else begin
                        set_btf <= 1'b1; // (R7) (R8) (R14) (R18)
                        if (rx_mode) begin
                           data_reg <= shreg;
                        end
                        state <= ST_WAIT;
                     end
                  end else begin
                     shreg <= {shreg[6:0], sda_s}; // (R3)
                     bitn <= bitn + 4'h1;
                     state <= ST_BIT_LO;
                  end
               end
            end
            ST_WAIT: begin
               // Failure wait does not stretch: clock released high (R20)
               if (ack_failure_flag && !hold) begin
                  scl_low <= 1'b0;
               end
               if (start_req) begin
                  state <= ST_START_A;
               end else if (stop_req && (clr_btf || !hold || tx_flag)) begin
                  state <= ST_STOP_A; // (R16) (R19)
               end else if (clr_addr) begin
                  is_addr <= 1'b0;
                  // Transmitter then waits for its first data byte (R18)
                  if (rx_mode) begin
                     state <= ST_BIT_LO;
                  end else begin
                     set_btf <= 1'b1;
                  end
               end else if (clr_btf && rx_mode) begin
                  state <= ST_BIT_LO; // (R15)
               end else if (clr_btf) begin
                  shreg <= req_i.wdata; // (R18)
                  state <= ST_BIT_LO;
               end
            end
            ST_STOP_A: begin
               scl_low <= 1'b1;
               sda_low <= 1'b1;
               if (ph_end) begin
                  state <= ST_STOP_B;
               end
            end
            ST_STOP_B: begin
               scl_low <= 1'b0;
               if (ph_end) begin
                  state <= ST_STOP_C;
               end
            end
            ST_STOP_C: begin
               sda_low <= 1'b0;
               if (ph_end) begin
                  master_idle_state <= 1'b0; // (R1) (R16)
                  stop_done <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   // ==========================================
   // Outputs; open-drain pins only pull low (R10)
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
         serial_clock_pin_o <= '0;
         serial_data_pin_o <= '0;
         pins_owned_o <= 1'b0;
      end else begin
         rdata_o <= next_rdata;
         irq_o <= irq_enable && event_flag; // (R11)
         serial_clock_pin_o <= '{o: 1'b0, oe: block_enable && scl_low}; // (R10)
         serial_data_pin_o <= '{o: 1'b0, oe: block_enable && sda_low};
         pins_owned_o <= block_enable;
      end
   end
endmodule
`default_nettype wire

// ===== sim/i2c_engine_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checker
module i2c_engine_sva (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire i2c_engine_pkg::reg_req_t req_i,
   input wire logic [7:0] rdata_o,
   input wire logic irq_o,
   input wire logic serial_clock_pin_i,
   input wire i2c_engine_pkg::od_pin_t serial_clock_pin_o,
   input wire logic serial_data_pin_i,
   input wire i2c_engine_pkg::od_pin_t serial_data_pin_o,
   input wire logic pins_owned_o
);
   import i2c_engine_pkg::*;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_pins_released_off: assert property (!pins_owned_o |-> !serial_clock_pin_o.oe && !serial_data_pin_o.oe)
      else $error("bus pin pulled while disabled");
   a_drain_only_low: assert property (serial_clock_pin_o.o == 1'b0 && serial_data_pin_o.o == 1'b0)
      else $error("pin driven high");
   a_st1_reserved_zero: assert property (req_i.rd && req_i.addr == 3'h1 |=> (rdata_o & 8'h54) == 8'h00)
      else $error("status one reserved bit set");
   a_st2_reserved_zero: assert property (req_i.rd && req_i.addr == 3'h2 |=> (rdata_o & 8'hEF) == 8'h00)
      else $error("status two reserved bit set");
   a_rdata_idle_zero: assert property (!req_i.rd || req_i.addr > 3'h4 |=> rdata_o == 8'h00)
      else $error("read data not zero");
   // Low phase is at least one divider phase (never under 2 cycles), or 2 cycles before the release after a missing ack
   a_scl_low_min: assert property ($rose(serial_clock_pin_o.oe) |-> serial_clock_pin_o.oe [*2])
      else $error("clock low phase too short");
   a_scl_high_min: assert property ($fell(serial_clock_pin_o.oe) |-> !serial_clock_pin_o.oe [*2])
      else $error("clock high phase too short");
   a_start_then_clock: assert property ($rose(serial_data_pin_o.oe) && !serial_clock_pin_o.oe
      |-> serial_data_pin_o.oe throughout (##[1:600] serial_clock_pin_o.oe))
      else $error("start condition not followed by clock low");
   a_irq_needs_enable: assert property (irq_o |-> pins_owned_o)
      else $error("interrupt while disabled");
endmodule
bind i2c_single_master_engine i2c_engine_sva u_i2c_engine_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o), .serial_clock_pin_i(serial_clock_pin_i),
   .serial_clock_pin_o(serial_clock_pin_o), .serial_data_pin_i(serial_data_pin_i),
   .serial_data_pin_o(serial_data_pin_o), .pins_owned_o(pins_owned_o));
`default_nettype wire

// ===== sim/i2c_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Write-only slave: takes bytes MSB first, acks its own address and data
module i2c_slave_model #(
   parameter logic [6:0] ADDR = 7'h50
) (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   output logic [7:0] last_addr_o,
   output logic [7:0] last_data_o
);
   logic [7:0] sh;
   int cnt;
   logic first;
   logic sel;
   initial begin
      sda_oe_o = 1'b0;
      cnt = 0;
      first = 1'b0;
      sel = 1'b0;
      last_addr_o = 8'h00;
      last_data_o = 8'h00;
   end
   always @(negedge sda_i) if (scl_i) begin
      cnt = 0;
      first = 1'b1;
   end
   always @(posedge sda_i) if (scl_i) sel = 1'b0;
   always @(posedge scl_i) begin
      if (cnt < 8) sh = {sh[6:0], sda_i};
      cnt = cnt + 1;
   end
   always @(negedge scl_i) begin
      if (cnt == 8) begin
         if (first) begin
            last_addr_o = sh;
            sel = (sh[7:1] == ADDR);
            first = 1'b0;
         end else if (sel) last_data_o = sh;
         sda_oe_o = sel;
      end else if (cnt == 9) begin
         sda_oe_o = 1'b0;
         cnt = 0;
      end
   end
endmodule
`default_nettype wire

// ===== sim/i2c_single_master_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_single_master_engine_bench;
   import i2c_engine_pkg::*;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   reg_req_t req = '0;
   logic [7:0] rdata_o;
   logic irq_o;
   od_pin_t scl_o;
   od_pin_t sda_o;
   logic pins_owned_o;
   logic slv_oe;
   logic [7:0] slv_addr;
   logic [7:0] slv_data;
   logic [7:0] d;
   logic pscl = 1'b0;
   int cnt = 0;
   int min_per = 1000;
   int n_fail = 0;
   int num_checks = 0;
   // Wired-AND with pull-ups: a released line reads high
   wire scl_w = !scl_o.oe;
   wire sda_w = !sda_o.oe && !slv_oe;
   always #12.5 clk_i = !clk_i;
   i2c_single_master_engine u_i2c_single_master_engine (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .req_i(req), .rdata_o(rdata_o), .irq_o(irq_o), .serial_clock_pin_i(scl_w),
      .serial_clock_pin_o(scl_o), .serial_data_pin_i(sda_w), .serial_data_pin_o(sda_o),
      .pins_owned_o(pins_owned_o));
   i2c_slave_model u_i2c_slave_model (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(slv_oe),
      .last_addr_o(slv_addr), .last_data_o(slv_data));
   // Shortest clock period seen, in cycles between rising bus clock edges
   always @(posedge clk_i) begin
      pscl <= scl_o.oe;
      cnt <= cnt + 1;
      if (!scl_o.oe && pscl) begin
         if (cnt < min_per) min_per <= cnt;
         cnt <= 1;
      end
   end
   task automatic close_out;
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(negedge clk_i) req = '{1'b0, 1'b1, a, v};
      @(negedge clk_i) req = '0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(negedge clk_i) req = '{1'b1, 1'b0, a, 8'h00};
      @(negedge clk_i) v = rdata_o;
      req = '0;
   endtask
   // Poll status one; the last access left behind is that read
   task automatic wt(input logic [7:0] m, input logic [7:0] v, output logic [7:0] s);
      for (int i = 0; i < 3000; i++) begin
         rd(3'h1, s);
         if ((s & m) === v) return;
      end
      chk(s & m, v);
      close_out();
   endtask
   initial begin
      repeat (2) @(negedge clk_i);
      rst_n_i = 1'b1;
      chk({7'h00, pins_owned_o}, 8'h00);
      wr(3'h0, 8'h29);
      rd(3'h0, d);
      chk(d, 8'h20);
      chk({7'h00, pins_owned_o}, 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr(3'h3, k ? 8'h81 : 8'h02);
         wr(3'h0, 8'h29);
         min_per = 1000;
         wt(8'h01, 8'h01, d);
         chk(d, 8'h83);
         chk({7'h00, irq_o}, 8'h01);
         wr(3'h4, 8'hA0);
         wt(8'h80, 8'h80, d);
         chk(d, 8'h82);
         wr(3'h0, 8'h21);
         rd(3'h1, d);
         wr(3'h4, 8'h5A);
         wr(3'h0, 8'h23);
         wt(8'h02, 8'h00, d);
         chk(d, 8'hA8);
         wr(3'h4, 8'h00);
         rd(3'h1, d);
         chk(d, 8'h00);
         chk(slv_addr, 8'hA0);
         chk(slv_data, 8'h5A);
         chk(min_per[7:0], k ? 8'h09 : 8'h08);
      end
      wr(3'h0, 8'h29);
      wt(8'h01, 8'h01, d);
      wr(3'h4, 8'hB0);
      wt(8'h80, 8'h80, d);
      repeat (20) @(negedge clk_i);
      chk({7'h00, scl_o.oe}, 8'h00);
      rd(3'h2, d);
      chk(d, 8'h10);
      wr(3'h0, 8'h23);
      wt(8'h02, 8'h00, d);
      wr(3'h0, 8'h00);
      rd(3'h0, d);
      chk(d, 8'h00);
      chk({7'h00, pins_owned_o}, 8'h00);
      rd(3'h3, d);
      chk(d, 8'h81);
      rd(3'h5, d);
      chk(d, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
